// *** hdl/mapeh_regs.vh ***
`ifndef MAPEH_REGS_VH
`define MAPEH_REGS_VH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define MAPEH_PORTS        2
`define MAPEH_AW           32
`define MAPEH_DW           32
`define MAPEH_AUTH_W       4

// ----------------------------------------
// Error handling version
// ----------------------------------------
`define MAPEH_ERR_VER      4'h1

// ----------------------------------------
// Controller states
// ----------------------------------------
`define MAPEH_ST_IDLE      2'h0
`define MAPEH_ST_CHECK     2'h1
`define MAPEH_ST_MEM       2'h2
`define MAPEH_ST_STOP      2'h3

// ----------------------------------------
// Access sizes
// ----------------------------------------
`define MAPEH_SZ_BYTE      3'h0
`define MAPEH_SZ_HALF      3'h1
`define MAPEH_SZ_WORD      3'h2

// ----------------------------------------
// Memory-side variants
// ----------------------------------------
`define MAPEH_VAR_APB      2'h0
`define MAPEH_VAR_AHB      2'h1
`define MAPEH_VAR_AXI      2'h2
`define MAPEH_VARIANT      2'h1

// ----------------------------------------
// Authentication bit positions
// ----------------------------------------
`define MAPEH_AUTH_DBGEN   0
`define MAPEH_AUTH_NIDEN   1
`define MAPEH_AUTH_SPIDEN  2
`define MAPEH_AUTH_SPNIDEN 3

// ----------------------------------------
// Cache attribute classes and domains
// ----------------------------------------
`define MAPEH_CA_DEV       3'h0
`define MAPEH_CA_NC        3'h1
`define MAPEH_CA_WT        3'h3
`define MAPEH_CA_WB_A      3'h5
`define MAPEH_CA_WB_B      3'h7
`define MAPEH_DOM_SYS      2'h3

`endif

// *** hdl/mapeh_sync2.v ***
`timescale 1ns/100ps
module mapeh_sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_rst,
  // Level in and out
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule // mapeh_sync2

// *** hdl/mapeh_err_state.v ***
`timescale 1ns/100ps
module mapeh_err_state (
  // Clock and reset
  input  wire i_clk,
  input  wire i_rst,
  // Events
  input  wire i_log_set,
  input  wire i_log_clr,
  input  wire i_tip_set,
  input  wire i_tip_clr,
  // State
  output reg  o_flag_ff,
  output reg  o_tip_ff
);
  // ----------------------------------------
  // Sticky error flag and busy bit
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_flag_ff <= 1'b0;
      o_tip_ff  <= 1'b0;
    end else begin
      if (i_log_set)
        o_flag_ff <= 1'b1;
      else if (i_log_clr)
        o_flag_ff <= 1'b0;
      if (i_tip_set)
        o_tip_ff <= 1'b1;
      else if (i_tip_clr)
        o_tip_ff <= 1'b0;
    end
  end
endmodule // mapeh_err_state

// *** hdl/mapeh_top.v ***
// Notes on behaviour
// - Memory errors set sticky flag; write-one clears.
// - Missing debug enables fail authentication.
// - Stop-on-error with flag set blocks transfers.
// - Memory-side error response logged as failure.
// - Abort always answers with error.
// - Memory access during post-abort busy gives error.
// - AXI only: bad cache/domain pair flagged.
// - Register errors never logged, always returned.
// - Register error only for write while busy.
// - No-pass set returns okay for maskable errors.
// - Stop-on-error clear lets accesses continue.
// - Read data zero on error answers.
// - Twin ports keep separate error state.
// - Non-maskable source always reported; maskable gated.
// - Auth changes mid-transfer apply next transaction.
// - Auth checked in check state, second cycle after leaving stop.
// - Reports error handling version one.
// - Size limits per memory-side variant.
// - No bursts, exclusives or unaligned transfers.
// - Abort answers now; memory transfer completes.
`timescale 1ns/100ps
`include "mapeh_regs.vh"
module mapeh_top (
  // Clock and reset
  input  wire                      i_clk,
  input  wire                      i_rst,
  // Debug request
  input  wire                      i_req_valid,
  input  wire                      i_req_port,
  input  wire                      i_req_mem,
  input  wire                      i_req_write,
  input  wire                      i_req_secure,
  input  wire [2:0]                i_req_size,
  input  wire [`MAPEH_AW-1:0]      i_req_addr,
  input  wire [`MAPEH_DW-1:0]      i_req_wdata,
  input  wire                      i_abort,
  // Debug answer
  output reg                       o_resp_valid_ff,
  output reg                       o_resp_err_ff,
  output reg  [`MAPEH_DW-1:0]      o_resp_rdata_ff,
  // Per-port control and shared cache and domain fields
  input  wire [`MAPEH_PORTS-1:0]   i_error_no_pass,
  input  wire [`MAPEH_PORTS-1:0]   i_stop_on_error,
  input  wire [`MAPEH_PORTS-1:0]   i_err_clear,
  input  wire [3:0]                i_cache_attribute_field,
  input  wire [1:0]                i_shareability_field,
  // Per-port status and shared version field
  output wire [`MAPEH_PORTS-1:0]   o_transfer_error_flag,
  output wire [`MAPEH_PORTS-1:0]   o_transfer_in_progress,
  output reg  [3:0]                o_err_version_ff,
  // Authentication pins
  input  wire [`MAPEH_AUTH_W-1:0]  i_auth,
  // Low-power channel
  input  wire                      i_qreq_n,
  output reg                       o_qaccept_n_ff,
  output reg                       o_qactive_ff,
  // Memory-side master
  output reg                       o_mem_req_ff,
  output reg                       o_mem_write_ff,
  output reg                       o_mem_secure_ff,
  output reg  [2:0]                o_mem_size_ff,
  output reg  [`MAPEH_AW-1:0]      o_mem_addr_ff,
  output reg  [`MAPEH_DW-1:0]      o_mem_wdata_ff,
  input  wire                      i_mem_done,
  input  wire                      i_mem_err,
  input  wire [`MAPEH_DW-1:0]      i_mem_rdata
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [1:0]                state_ff;
  reg  [1:0]                nxt_state;
  reg                       port_ff;
  reg                       write_ff;
  reg                       secure_ff;
  reg  [2:0]                size_ff;
  reg  [`MAPEH_AW-1:0]      addr_ff;
  reg  [`MAPEH_DW-1:0]      wdata_ff;
  reg                       drain_port_ff;
  wire [`MAPEH_AUTH_W-1:0]  auth_s;
  wire                      qreq_n_s;
  reg  [`MAPEH_PORTS-1:0]   log_set;
  reg  [`MAPEH_PORTS-1:0]   tip_set;
  reg  [`MAPEH_PORTS-1:0]   tip_clr;
  wire                      take;
  wire                      no_pass;
  wire                      stop_err;
  wire                      busy_err;
  wire                      auth_err;
  wire                      size_err;
  wire                      align_err;
  wire                      inval_err;
  wire                      mask_err;
  wire                      mem_fin;
  wire                      aborted_fin;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  mapeh_sync2 #(
    .W (`MAPEH_AUTH_W)
  ) u_auth_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_auth),
    .o_sync  (auth_s)
  );

  mapeh_sync2 #(
    .W (1)
  ) u_qreq_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_qreq_n),
    .o_sync  (qreq_n_s)
  );

  // ----------------------------------------
  // Per-port error state
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `MAPEH_PORTS; g = g + 1) begin : g_port
      mapeh_err_state u_err (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_log_set (log_set[g]),
        .i_log_clr (i_err_clear[g]),
        .i_tip_set (tip_set[g]),
        .i_tip_clr (tip_clr[g]),
        .o_flag_ff (o_transfer_error_flag[g]),
        .o_tip_ff  (o_transfer_in_progress[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Cache and domain pairing check
  // ----------------------------------------
  function cache_ok;
    input [3:0] cache;
    input [1:0] dom;
    begin
      case (cache[3:1])
        `MAPEH_CA_DEV:  cache_ok = (dom == `MAPEH_DOM_SYS);
        `MAPEH_CA_NC:   cache_ok = 1'b1;
        `MAPEH_CA_WT,
        `MAPEH_CA_WB_A,
        `MAPEH_CA_WB_B: cache_ok = (dom != `MAPEH_DOM_SYS);
        default:        cache_ok = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Error sources for the held request
  // ----------------------------------------
  assign take     = (state_ff == `MAPEH_ST_IDLE) & i_req_valid & ~o_resp_valid_ff;
  assign no_pass  = i_error_no_pass[port_ff];
  assign stop_err = i_stop_on_error[port_ff] &
                    o_transfer_error_flag[port_ff];
  assign busy_err = o_transfer_in_progress[port_ff];
  assign auth_err = ~(auth_s[`MAPEH_AUTH_DBGEN] | auth_s[`MAPEH_AUTH_NIDEN]) |
                    (secure_ff & ~(auth_s[`MAPEH_AUTH_SPIDEN] |
                                   auth_s[`MAPEH_AUTH_SPNIDEN]));
  assign size_err = (`MAPEH_VARIANT == `MAPEH_VAR_APB) ?
                    (size_ff != `MAPEH_SZ_WORD) :
                    (size_ff > `MAPEH_SZ_WORD);
  assign align_err = ((size_ff == `MAPEH_SZ_HALF) & addr_ff[0]) |
                     ((size_ff == `MAPEH_SZ_WORD) & (|addr_ff[1:0]));
  assign inval_err = (`MAPEH_VARIANT == `MAPEH_VAR_AXI) &
                     ~cache_ok(i_cache_attribute_field, i_shareability_field);
  assign mask_err  = auth_err | stop_err | size_err | align_err | inval_err;
  assign mem_fin     = o_mem_req_ff & i_mem_done;
  assign aborted_fin = mem_fin & (state_ff != `MAPEH_ST_MEM);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `MAPEH_ST_IDLE: begin
        if (take & i_req_mem)
          nxt_state = `MAPEH_ST_CHECK;
        else if (~i_req_valid & ~qreq_n_s & ~o_mem_req_ff)
          nxt_state = `MAPEH_ST_STOP;
      end
      `MAPEH_ST_CHECK: begin
        if (i_abort | busy_err | mask_err)
          nxt_state = `MAPEH_ST_IDLE;
        else if (~o_mem_req_ff)
          nxt_state = `MAPEH_ST_MEM;
      end
      `MAPEH_ST_MEM: begin
        if (i_abort | mem_fin)
          nxt_state = `MAPEH_ST_IDLE;
      end
      `MAPEH_ST_STOP: begin
        if (qreq_n_s)
          nxt_state = `MAPEH_ST_IDLE;
      end
      default: nxt_state = `MAPEH_ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Error state events
  // ----------------------------------------
  always @* begin
    log_set = {`MAPEH_PORTS{1'b0}};
    tip_set = {`MAPEH_PORTS{1'b0}};
    tip_clr = {`MAPEH_PORTS{1'b0}};
    if (state_ff == `MAPEH_ST_CHECK) begin
      if (i_abort | busy_err | mask_err)
        log_set[port_ff] = 1'b1;
    end
    if (state_ff == `MAPEH_ST_MEM) begin
      if (i_abort & ~mem_fin) begin
        log_set[port_ff] = 1'b1;
        tip_set[port_ff] = 1'b1;
      end else if (i_abort | (mem_fin & i_mem_err)) begin
        log_set[port_ff] = 1'b1;
      end
    end
    if (aborted_fin)
      tip_clr[drain_port_ff] = 1'b1;
  end

  // ----------------------------------------
  // Request capture and controller
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      state_ff       <= `MAPEH_ST_IDLE;
      port_ff        <= 1'b0;
      write_ff       <= 1'b0;
      secure_ff      <= 1'b0;
      size_ff        <= `MAPEH_SZ_WORD;
      addr_ff        <= {`MAPEH_AW{1'b0}};
      wdata_ff       <= {`MAPEH_DW{1'b0}};
      drain_port_ff  <= 1'b0;
      o_qaccept_n_ff <= 1'b1;
      o_qactive_ff   <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      o_qaccept_n_ff <= (nxt_state != `MAPEH_ST_STOP);
      o_qactive_ff   <= i_req_valid | o_mem_req_ff;
      if (take) begin
        port_ff   <= i_req_port;
        write_ff  <= i_req_write;
        secure_ff <= i_req_secure;
        size_ff   <= i_req_size;
        addr_ff   <= i_req_addr;
        wdata_ff  <= i_req_wdata;
      end
      if (state_ff == `MAPEH_ST_MEM)
        drain_port_ff <= port_ff;
    end
  end

  // ----------------------------------------
  // Debug answer
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_resp_valid_ff  <= 1'b0;
      o_resp_err_ff    <= 1'b0;
      o_resp_rdata_ff  <= {`MAPEH_DW{1'b0}};
      o_err_version_ff <= `MAPEH_ERR_VER;
    end else begin
      o_err_version_ff <= `MAPEH_ERR_VER;
      o_resp_valid_ff  <= 1'b0;
      o_resp_err_ff    <= 1'b0;
      o_resp_rdata_ff  <= {`MAPEH_DW{1'b0}};
      if (take & ~i_req_mem) begin
        o_resp_valid_ff <= 1'b1;
        o_resp_err_ff   <= i_req_write &
                           o_transfer_in_progress[i_req_port];
      end
      if (state_ff == `MAPEH_ST_CHECK) begin
        if (i_abort) begin
          o_resp_valid_ff <= 1'b1;
          o_resp_err_ff   <= 1'b1;
        end else if (busy_err | mask_err) begin
          o_resp_valid_ff <= 1'b1;
          o_resp_err_ff   <= busy_err | (mask_err & ~no_pass);
        end
      end
      if (state_ff == `MAPEH_ST_MEM) begin
        if (i_abort) begin
          o_resp_valid_ff <= 1'b1;
          o_resp_err_ff   <= 1'b1;
        end else if (mem_fin) begin
          o_resp_valid_ff <= 1'b1;
          o_resp_err_ff   <= i_mem_err & ~no_pass;
          if (~i_mem_err & ~write_ff)
            o_resp_rdata_ff <= i_mem_rdata;
        end
      end
    end
  end

  // ----------------------------------------
  // Memory-side master, single transfers only
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_mem_req_ff    <= 1'b0;
      o_mem_write_ff  <= 1'b0;
      o_mem_secure_ff <= 1'b0;
      o_mem_size_ff   <= `MAPEH_SZ_WORD;
      o_mem_addr_ff   <= {`MAPEH_AW{1'b0}};
      o_mem_wdata_ff  <= {`MAPEH_DW{1'b0}};
    end else begin
      if (mem_fin)
        o_mem_req_ff <= 1'b0;
      else if ((state_ff == `MAPEH_ST_CHECK) & (nxt_state == `MAPEH_ST_MEM)) begin
        o_mem_req_ff    <= 1'b1;
        o_mem_write_ff  <= write_ff;
        o_mem_secure_ff <= secure_ff;
        o_mem_size_ff   <= size_ff;
        o_mem_addr_ff   <= addr_ff;
        o_mem_wdata_ff  <= wdata_ff;
      end
    end
  end

endmodule // mapeh_top

// *** tb/mapeh_props.sv ***
`timescale 1ns/100ps
module mapeh_props (
  // Clock and reset
  input wire        i_clk,
  input wire        i_rst,
  // Request and answer
  input wire        i_req_port,
  input wire        i_abort,
  input wire        o_resp_valid_ff,
  input wire        o_resp_err_ff,
  input wire [31:0] o_resp_rdata_ff,
  // Control and status
  input wire [1:0]  i_error_no_pass,
  input wire [1:0]  i_stop_on_error,
  input wire [1:0]  i_err_clear,
  input wire [1:0]  o_transfer_error_flag,
  input wire [1:0]  o_transfer_in_progress,
  input wire [3:0]  o_err_version_ff,
  // Memory side
  input wire        o_mem_req_ff,
  input wire        o_mem_write_ff,
  input wire [2:0]  o_mem_size_ff,
  input wire [31:0] o_mem_addr_ff,
  input wire        i_mem_done,
  input wire        i_mem_err,
  input wire [31:0] i_mem_rdata
);
  // ----
  // Helpers
  // ----
  reg blocked_ff;
  reg no_pass_ff;
  always @(posedge i_clk) begin
    blocked_ff <= i_stop_on_error[i_req_port] & o_transfer_error_flag[i_req_port];
    no_pass_ff <= i_error_no_pass[i_req_port];
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence abort_s;
    i_abort && o_mem_req_ff && !i_mem_done && o_transfer_in_progress == 2'h0;
  endsequence
  sequence done_s;
    o_mem_req_ff && i_mem_done && !i_abort && o_transfer_in_progress == 2'h0;
  endsequence
  // ----
  // Checks
  // ----
  ver_const_a: assert property (o_err_version_ff == 4'h1)
    else $error("version field wrong");
  flag_sticky_a: assert property ((o_transfer_error_flag[0] && !i_err_clear[0] |=>
    o_transfer_error_flag[0]) and (o_transfer_error_flag[1] && !i_err_clear[1] |=>
    o_transfer_error_flag[1])) else $error("error flag dropped");
  stop_block_a: assert property ($rose(o_mem_req_ff) |-> !blocked_ff)
    else $error("transfer started while stopped");
  abort_ans_a: assert property (abort_s |=> o_resp_valid_ff && o_resp_err_ff)
    else $error("abort not answered with error");
  tip_set_a: assert property (abort_s |=> o_transfer_in_progress != 2'h0 && o_mem_req_ff)
    else $error("busy bit not set after abort");
  req_hold_a: assert property (o_mem_req_ff && !i_mem_done |=> o_mem_req_ff)
    else $error("memory request cancelled");
  tip_clear_a: assert property (o_mem_req_ff && i_mem_done |=>
    !o_mem_req_ff && o_transfer_in_progress == 2'h0) else $error("busy not cleared");
  mem_err_a: assert property (done_s ##0 i_mem_err |=> o_resp_valid_ff &&
    o_resp_err_ff == !no_pass_ff && o_transfer_error_flag[i_req_port])
    else $error("memory error not handled");
  mem_ok_a: assert property (done_s ##0 !i_mem_err |=> o_resp_valid_ff &&
    !o_resp_err_ff && (o_mem_write_ff || o_resp_rdata_ff == $past(i_mem_rdata)))
    else $error("good transfer answered wrongly");
  size_ok_a: assert property (o_mem_req_ff |-> o_mem_size_ff == 3'h0 ||
    o_mem_size_ff == 3'h1 && !o_mem_addr_ff[0] ||
    o_mem_size_ff == 3'h2 && o_mem_addr_ff[1:0] == 2'h0) else $error("bad size or align");
endmodule // mapeh_props

bind mapeh_top mapeh_props mapeh_props_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_req_port(i_req_port), .i_abort(i_abort),
  .o_resp_valid_ff(o_resp_valid_ff), .o_resp_err_ff(o_resp_err_ff),
  .o_resp_rdata_ff(o_resp_rdata_ff), .i_error_no_pass(i_error_no_pass),
  .i_stop_on_error(i_stop_on_error), .i_err_clear(i_err_clear),
  .o_transfer_error_flag(o_transfer_error_flag), .o_transfer_in_progress(o_transfer_in_progress),
  .o_err_version_ff(o_err_version_ff), .o_mem_req_ff(o_mem_req_ff),
  .o_mem_write_ff(o_mem_write_ff), .o_mem_size_ff(o_mem_size_ff), .o_mem_addr_ff(o_mem_addr_ff),
  .i_mem_done(i_mem_done), .i_mem_err(i_mem_err), .i_mem_rdata(i_mem_rdata));

// *** tb/mapeh_mem_model.sv ***
`timescale 1ns/100ps
module mapeh_mem_model (
  // Clock and request
  input  wire        i_clk,
  input  wire        i_req,
  input  wire [31:0] i_addr,
  // Behaviour set by bench
  input  wire [7:0]  i_lat,
  input  wire        i_err,
  // Answer
  output reg         o_done,
  output reg         o_err,
  output reg  [31:0] o_rdata,
  output reg  [7:0]  o_starts
);
  reg [7:0] cnt_ff;
  initial begin
    o_done = 1'b0;
    o_err = 1'b0;
    o_rdata = 32'h0;
    o_starts = 8'h0;
    cnt_ff = 8'h0;
  end
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    o_err <= ~o_err;
    o_rdata <= ~o_rdata;
    if (i_req && !o_done) begin
      if (cnt_ff == 8'h0) o_starts <= o_starts + 8'h1;
      cnt_ff <= cnt_ff + 8'h1;
      if (cnt_ff >= i_lat) begin // Runs to completion
        o_done <= 1'b1;
        o_err <= i_err;
        o_rdata <= ~i_addr;
        cnt_ff <= 8'h0;
      end
    end
  end
endmodule // mapeh_mem_model

// *** tb/tb.sv ***
`timescale 1ns/100ps
module tb;
  reg         clk, rst, valid, port, mem, wr, sec, abort, qreq_n, merr, got_err;
  reg  [2:0]  size;
  reg  [31:0] addr, wdata, got_data;
  reg  [1:0]  np, stop, clr;
  reg  [3:0]  auth;
  reg  [7:0]  lat, s0;
  wire        rv, re, qa_n, qact, mreq, mdone, merr_w;
  wire [31:0] rdata, maddr, mrdata, mwdata;
  wire [1:0]  flag, tip;
  wire [3:0]  ver;
  wire [7:0]  starts;
  integer     bad_count, check_count, cyc, n;

  mapeh_top mapeh_top_i (
    .i_clk(clk), .i_rst(rst), .i_req_valid(valid), .i_req_port(port), .i_req_mem(mem),
    .i_req_write(wr), .i_req_secure(sec), .i_req_size(size), .i_req_addr(addr),
    .i_req_wdata(wdata), .i_abort(abort), .o_resp_valid_ff(rv), .o_resp_err_ff(re),
    .o_resp_rdata_ff(rdata), .i_error_no_pass(np), .i_stop_on_error(stop), .i_err_clear(clr),
    .i_cache_attribute_field(4'h0), .i_shareability_field(2'h3),
    .o_transfer_error_flag(flag), .o_transfer_in_progress(tip), .o_err_version_ff(ver),
    .i_auth(auth), .i_qreq_n(qreq_n), .o_qaccept_n_ff(qa_n), .o_qactive_ff(qact),
    .o_mem_req_ff(mreq), .o_mem_write_ff(), .o_mem_secure_ff(), .o_mem_size_ff(),
    .o_mem_addr_ff(maddr), .o_mem_wdata_ff(mwdata), .i_mem_done(mdone), .i_mem_err(merr_w),
    .i_mem_rdata(mrdata));
  mapeh_mem_model mapeh_mem_model_i (.i_clk(clk), .i_req(mreq), .i_addr(maddr), .i_lat(lat),
    .i_err(merr), .o_done(mdone), .o_err(merr_w), .o_rdata(mrdata), .o_starts(starts));

  // ----
  // Tasks
  // ----
  task check(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (bad_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task go(input p, input m, input w, input s, input [2:0] z, input [31:0] a);
    begin
      @(posedge clk); #1;
      {port, mem, wr, sec, size, addr, wdata} = {p, m, w, s, z, a, ~a};
      valid = 1'b1;
    end
  endtask
  task wait_resp;
    begin
      for (n = 0; n < 200 && rv !== 1'b1; n = n + 1) begin
        @(posedge clk); #1;
      end
      check(n < 200, 1);
      got_err = re;
      got_data = rdata;
      valid = 1'b0;
    end
  endtask
  task do_req(input p, input m, input w, input s, input [2:0] z, input [31:0] a);
    begin
      go(p, m, w, s, z, a);
      wait_resp;
    end
  endtask
  task clear_flags;
    begin
      @(posedge clk); #1 clr = 2'h3;
      @(posedge clk); #1 clr = 2'h0;
      check(flag, 0);
    end
  endtask
  task wait_clk(input integer k);
    repeat (k) @(posedge clk);
  endtask

  // ----
  // Scenarios
  // ----
  task t_basic;
    begin
      do_req(0, 1, 0, 0, 3'h2, 32'h100);
      check(got_err, 0);
      check(got_data, ~32'h100);
      do_req(0, 0, 1, 0, 3'h2, 32'h0);
      check(got_err, 0);
      check(ver, 1);
    end
  endtask
  task t_mem_err;
    begin
      merr = 1'b1;
      np = 2'h2;
      do_req(0, 1, 0, 0, 3'h2, 32'h8);
      check(got_err, 1);
      check(flag, 1);
      do_req(1, 1, 1, 0, 3'h2, 32'h8);
      check(got_err, 0);
      check(flag, 3);
      merr = 1'b0;
      do_req(0, 1, 0, 0, 3'h2, 32'h4);
      check(got_err, 0);
      np = 2'h0;
      clear_flags;
    end
  endtask
  task t_auth;
    begin
      auth = 4'hC;
      wait_clk(3);
      s0 = starts;
      do_req(0, 1, 0, 0, 3'h2, 32'h0);
      check({got_err, starts}, {1'b1, s0});
      auth = 4'h3;
      wait_clk(3);
      do_req(0, 1, 0, 1, 3'h2, 32'h0);
      check(got_err, 1);
      do_req(0, 1, 0, 0, 3'h2, 32'h0);
      check(got_err, 0);
      lat = 8'h8;
      go(0, 1, 0, 0, 3'h2, 32'h20);
      wait_clk(4);
      #1 auth = 4'h0;
      wait_resp;
      check(got_err, 0);
      auth = 4'hF;
      lat = 8'h2;
      clear_flags;
    end
  endtask
  task t_stop;
    begin
      merr = 1'b1;
      do_req(0, 1, 0, 0, 3'h2, 32'h0);
      merr = 1'b0;
      stop = 2'h1;
      s0 = starts;
      do_req(0, 1, 0, 0, 3'h2, 32'h0);
      check({got_err, starts, flag}, {1'b1, s0, 2'h1});
      np = 2'h1;
      do_req(0, 1, 0, 0, 3'h2, 32'h0);
      check(got_err, 0);
      do_req(1, 1, 0, 0, 3'h2, 32'h0);
      check({got_err, starts}, {1'b0, s0 + 8'h1});
      {np, stop} = 4'h0;
      do_req(0, 1, 0, 0, 3'h2, 32'h0);
      check(got_err, 0);
      clear_flags;
    end
  endtask
  task t_abort;
    begin
      lat = 8'h1E;
      np = 2'h3;
      go(0, 1, 0, 0, 3'h2, 32'h40);
      for (n = 0; n < 10 && mreq !== 1'b1; n = n + 1) begin
        @(posedge clk); #1;
      end
      abort = 1'b1;
      @(posedge clk); #1 abort = 1'b0;
      check({rv, re}, 3);
      valid = 1'b0;
      check({tip, mreq}, 3);
      do_req(0, 1, 0, 0, 3'h2, 32'h0);
      check(got_err, 1);
      clear_flags;
      check(qact, 1);
      do_req(0, 0, 1, 0, 3'h2, 32'h0);
      check({got_err, flag}, 4);
      do_req(0, 0, 0, 0, 3'h2, 32'h0);
      check(got_err, 0);
      for (n = 0; n < 60 && tip !== 2'h0; n = n + 1) wait_clk(1);
      #1 check(tip, 0);
      wait_clk(1);
      #1 check(qact, 0);
      lat = 8'h2;
      np = 2'h0;
      clear_flags;
    end
  endtask
  task t_size;
    begin
      do_req(0, 1, 0, 0, 3'h3, 32'h0);
      check(got_err, 1);
      do_req(0, 1, 0, 0, 3'h1, 32'h1);
      check(got_err, 1);
      do_req(0, 1, 1, 0, 3'h0, 32'h3);
      check(got_err, 0);
      check(mwdata, ~32'h3);
      clear_flags;
    end
  endtask
  task t_qstop;
    begin
      auth = 4'h0;
      qreq_n = 1'b0;
      for (n = 0; n < 50 && qa_n !== 1'b0; n = n + 1) wait_clk(1);
      #1 check(qa_n, 0);
      go(0, 1, 0, 0, 3'h2, 32'h10);
      wait_clk(4);
      #1 auth = 4'hF;
      qreq_n = 1'b1;
      wait_resp;
      check({got_err, qa_n}, 1);
    end
  endtask

  // ----
  // Main
  // ----
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst, valid, port, mem, wr, sec, abort, qreq_n, merr} = 9'h102;
    {size, addr, wdata, np, stop, clr} = {3'h2, 70'h0};
    auth = 4'hF;
    lat = 8'h2;
    bad_count = 0;
    check_count = 0;
    wait_clk(8);
    #1 rst = 1'b0;
    check({flag, tip}, 0);
    wait_clk(3);
    t_basic;
    t_mem_err;
    t_auth;
    t_stop;
    t_abort;
    t_size;
    t_qstop;
    tally_and_finish;
  end
  initial cyc = 0;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  end
endmodule // tb
